//--- hw/smd_monitor.sv
/*
  Passive serial bus monitor: samples clock, select and data lines,
  builds words and frames, queues words and raises trigger pulses.
  Assumes configuration is static while frames run, and that the
  observed clock is well below a quarter of the sampling rate.
*/
`timescale 1ns/1ps
module smd_monitor
  import smd_pkg::*;
#(
  parameter int INSTANCE = 1,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Observed lines
  input wire logic sclk_in,
  input wire logic cs_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  // Configuration
  input wire smd_cfg_t cfg_in,
  // Word stream
  output smd_word_t word_out,
  output logic word_valid_out,
  input wire logic word_ready_in,
  // Events and status
  output logic trig_out,
  output logic frame_start_out,
  output logic frame_end_out,
  output logic in_frame_out,
  output logic partner_claimed_out,
  output logic overflow_out
);
  // Second line only on instances 1 and 3
  localparam bit MISO_OK = (INSTANCE == 1) || (INSTANCE == 3);

  logic [3:0] raw_s;
  logic sclk_q;
  logic in_frame_q;
  logic [5:0] bit_q;
  logic [CNT_W-1:0] word_idx_q;
  logic [CNT_W-1:0] bitnum_q;
  logic [CNT_W-1:0] idle_q;
  logic [31:0] sh_mosi_q;
  logic [31:0] sh_miso_q;
  logic [31:0] hist_q;
  logic first_q;
  logic cs_act_q;
  smd_word_t word_q;
  logic push_q;
  logic trig_q;
  logic fs_q;
  logic fe_q;
  logic ovf_q;
  logic claim_q;
  logic fifo_ready;
  logic [1:0] warm_q;

  // Pins go through two flops before anything reads them
  smd_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({sclk_in, cs_in, mosi_in, miso_in}),
    .sync_out(raw_s)
  );

  // Edges are ignored until the synchroniser holds real pin levels,
  // otherwise its reset value would look like a select or clock edge
  wire live = (warm_q == 2'h3);

  wire cs_act = (raw_s[2] == cfg_in.cs_act_high);
  wire mosi_b = (raw_s[1] == cfg_in.mosi_act_high);
  wire miso_use = MISO_OK && cfg_in.miso_en;
  wire miso_b = miso_use && (raw_s[0] == cfg_in.miso_act_high);

  wire rise = live && raw_s[3] && !sclk_q;
  wire fall = live && !raw_s[3] && sclk_q;
  wire bit_edge = cfg_in.slope_fall ? fall : rise;
  wire any_edge = rise || fall;

  // select framing only in select mode
  wire cs_start = live && cfg_in.cs_mode && cs_act && !cs_act_q;
  wire cs_end = live && cfg_in.cs_mode && !cs_act && cs_act_q;
  wire idle_done = !cfg_in.cs_mode && in_frame_q &&
    (idle_q >= cfg_in.idle_cyc);
  wire nocs_start = !cfg_in.cs_mode && !in_frame_q && bit_edge;
  wire f_start = cs_start || nocs_start;
  wire f_end = cs_end || idle_done;
  wire sample = bit_edge && (nocs_start || (in_frame_q && !f_end &&
    (!cfg_in.cs_mode || cs_act)));

  wire [5:0] wsize = (cfg_in.word_size == 6'h00) ? 6'h01 :
    ((cfg_in.word_size > 6'h20) ? 6'h20 : cfg_in.word_size);
  wire [5:0] bit_cur = nocs_start ? 6'h00 : bit_q;
  wire [CNT_W-1:0] bitnum_cur = nocs_start ? '0 : bitnum_q;
  wire [CNT_W-1:0] widx_cur = nocs_start ? '0 : word_idx_q;
  wire [5:0] bit_nxt = bit_cur + 6'h01;
  wire word_full = sample && (bit_nxt == wsize);
  wire partial = f_end && (bit_q != 6'h00);

  function automatic logic [31:0] place(input logic [31:0] sh,
                                        input logic b,
                                        input logic lsb,
                                        input logic [5:0] idx);
    logic [31:0] r;
    r = sh;
    if (lsb) begin
      r[idx[4:0]] = b;
    end else begin
      r = {sh[30:0], b};
    end
    return r;
  endfunction
  wire [31:0] mosi_nx = place(sh_mosi_q, mosi_b, cfg_in.lsb_first,
    bit_cur);
  wire [31:0] miso_nx = place(sh_miso_q, miso_b, cfg_in.lsb_first,
    bit_cur);

  wire trig_b = (miso_use && cfg_in.trig_miso) ? miso_b : mosi_b;
  wire [31:0] hist_nx = {hist_q[30:0], trig_b};
  wire [CNT_W-1:0] bitnum_nx = bitnum_cur + 1'b1;
  wire [31:0] len_mask = (cfg_in.pat_len >= 6'h20) ? 32'hFFFFFFFF :
    ((32'h00000001 << cfg_in.pat_len[4:0]) - 32'h00000001);
  wire [31:0] care = len_mask & cfg_in.pat_care;
  wire pat_hit = sample && (cfg_in.pat_len != 6'h00) &&
    (bitnum_nx == cfg_in.bit_offset + CNT_W'(cfg_in.pat_len)) &&
    (((hist_nx ^ cfg_in.pat_val) & care) == 32'h00000000);
  wire bit_hit = sample && (bitnum_nx == cfg_in.bit_offset + 1'b1);
  wire trig_d = (cfg_in.trig_mode == SMD_TRIG_START) ? f_start :
    (cfg_in.trig_mode == SMD_TRIG_END) ? f_end :
    (cfg_in.trig_mode == SMD_TRIG_BIT) ? bit_hit : pat_hit;

  wire push_d = word_full || partial;

  // Line history and select edge state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_q <= 1'b0;
      cs_act_q <= 1'b0;
      warm_q <= 2'h0;
    end else begin
      sclk_q <= raw_s[3];
      cs_act_q <= live && cfg_in.cs_mode && cs_act;
      if (!live) begin
        warm_q <= warm_q + 2'h1;
      end
    end
  end

  // Frame state and idle timer; any clock edge keeps frame alive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      in_frame_q <= 1'b0;
      idle_q <= '0;
    end else begin
      if (f_start) begin
        in_frame_q <= 1'b1;
      end else if (f_end) begin
        in_frame_q <= 1'b0;
      end
      if (any_edge || !in_frame_q) begin
        idle_q <= '0;
      end else if (idle_q != {CNT_W{1'b1}}) begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || cs_start || f_end) begin
      bit_q <= '0;
      bitnum_q <= '0;
      word_idx_q <= '0;
      sh_mosi_q <= '0;
      sh_miso_q <= '0;
      hist_q <= '0;
      first_q <= 1'b1;
    end else if (sample) begin
      bit_q <= word_full ? 6'h00 : bit_nxt;
      bitnum_q <= bitnum_nx;
      hist_q <= hist_nx;
      sh_mosi_q <= word_full ? 32'h00000000 : mosi_nx;
      sh_miso_q <= word_full ? 32'h00000000 : miso_nx;
      if (word_full) begin
        word_idx_q <= widx_cur + 1'b1;
        first_q <= 1'b0;
      end
    end
  end

  // both directions captured in one word record
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_q <= '0;
      push_q <= 1'b0;
    end else begin
      push_q <= push_d;
      if (push_d) begin
        word_q.mosi <= word_full ? mosi_nx : sh_mosi_q;
        word_q.miso <= word_full ? miso_nx : sh_miso_q;
        word_q.nbits <= word_full ? wsize : bit_q;
        word_q.first <= first_q || nocs_start;
        word_q.last <= f_end;
        word_q.word_idx <= widx_cur;
      end
    end
  end

  // Event pulses, sticky overflow flag and claim status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trig_q <= 1'b0;
      fs_q <= 1'b0;
      fe_q <= 1'b0;
      ovf_q <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
      fs_q <= f_start;
      fe_q <= f_end;
      claim_q <= miso_use;
      if (push_q && !fifo_ready) begin
        ovf_q <= 1'b1;
      end
    end
  end

  assign partner_claimed_out = claim_q;
  // no acknowledge or address stage exists in the datapath

  // Word queue; a full queue drops the word and flags overflow,
  // since a passive monitor cannot stall the observed bus
  smd_word_t fifo_q_data;
  logic fifo_q_valid;
  smd_fifo #(.WIDTH($bits(smd_word_t)), .DEPTH(DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push_q),
    .in_ready_out(fifo_ready),
    .in_data_in(word_q),
    .out_valid_out(fifo_q_valid),
    .out_ready_in(word_ready_in && !word_valid_out),
    .out_data_out(fifo_q_data)
  );

  // Output register stage so the stream leaves from flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_valid_out <= 1'b0;
      word_out <= '0;
    end else if (!word_valid_out || word_ready_in) begin
      word_valid_out <= fifo_q_valid && word_ready_in &&
        !word_valid_out;
      word_out <= fifo_q_data;
    end
  end

  assign trig_out = trig_q;
  assign frame_start_out = fs_q;
  assign frame_end_out = fe_q;
  assign in_frame_out = in_frame_q;
  assign overflow_out = ovf_q;

  // Checks
  AST_START_CLR: assert property (@(posedge clk_in) disable iff (rst_in)
    f_start |=> (bit_q <= 6'h01))
    else $error("counters not cleared at frame start");
  AST_WSIZE: assert property (@(posedge clk_in) disable iff (rst_in)
    bit_q < 6'h20)
    else $error("bit count beyond 32");
  AST_CS_FRAME: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.cs_mode && $rose(cs_act_q) |-> in_frame_q)
    else $error("select did not open a frame");
  AST_CS_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.cs_mode && in_frame_q && cs_act |=> in_frame_q)
    else $error("select frame closed while select active");
  AST_NOCS_GAP: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_in.cs_mode && in_frame_q && any_edge |=> in_frame_q)
    else $error("short gap split frame");
  AST_IDLE_END: assert property (@(posedge clk_in) disable iff (rst_in)
    idle_done |=> !in_frame_q)
    else $error("idle expiry did not close frame");
  AST_TRIG_START: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.trig_mode == SMD_TRIG_START && f_start |=> trig_out)
    else $error("missing start trigger");
  AST_MISO_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    push_q && !miso_use |-> word_q.miso == 32'h00000000)
    else $error("unused line reached a word");
  AST_CLAIM: assert property (@(posedge clk_in) disable iff (rst_in)
    MISO_OK && cfg_in.miso_en |=> partner_claimed_out)
    else $error("second line enabled but partner not claimed");
  AST_CLAIM_ODD: assert property (@(posedge clk_in) disable iff (rst_in)
    partner_claimed_out |-> MISO_OK && cfg_in.miso_en)
    else $error("claim without enabled second line");
  AST_PUSH: assert property (@(posedge clk_in) disable iff (rst_in)
    word_full |=> push_q && word_q.nbits == wsize)
    else $error("full word not queued");
  COV_FULL: cover property (@(posedge clk_in) word_full);
  COV_PART: cover property (@(posedge clk_in) partial);
  COV_PAT: cover property (@(posedge clk_in) pat_hit);
endmodule

//--- hw/smd_pkg.sv
/*
  Shared constants and carrier types for the serial bus monitor.
  Assumes a 100 MHz sampling clock and lines already digitised.
*/
package smd_pkg;
  localparam int CLK_MHZ = 100;
  localparam int MAX_WORD = 32;
  localparam int IDLE_NS_DEF = 1000;
  localparam int IDLE_CYC_DEF = (IDLE_NS_DEF * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic POL_CS_RST = 1'b0;
  localparam logic POL_DATA_RST = 1'b1;
  localparam logic [5:0] WSIZE_RST = 6'h08;

  typedef enum logic [1:0] {
    SMD_TRIG_START,
    SMD_TRIG_END,
    SMD_TRIG_BIT,
    SMD_TRIG_PATTERN
  } smd_trig_t;

  typedef struct packed {
    logic cs_mode;
    logic slope_fall;
    logic cs_act_high;
    logic mosi_act_high;
    logic miso_act_high;
    logic miso_en;
    logic lsb_first;
    logic trig_miso;
    logic [5:0] word_size;
    logic [CNT_W-1:0] idle_cyc;
    smd_trig_t trig_mode;
    logic [CNT_W-1:0] bit_offset;
    logic [5:0] pat_len;
    logic [31:0] pat_val;
    logic [31:0] pat_care;
  } smd_cfg_t;

  typedef struct packed {
    logic [31:0] mosi;
    logic [31:0] miso;
    logic [5:0] nbits;
    logic first;
    logic last;
    logic [CNT_W-1:0] word_idx;
  } smd_word_t;
endpackage

//--- hw/smd_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous lines.
  Assumes the inputs are levels, each changing slower than the clock.
*/
`timescale 1ns/1ps
module smd_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Lines
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // Only the second stage is read by others
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- hw/smd_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock; full and empty are exact.
*/
`timescale 1ns/1ps
module smd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem[rp_q];

  // Storage has no reset; only pointers and the count do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_q] <= in_data_in;
    end
  end

  // Pointers wrap, so DEPTH should be a power of two
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- tb/smd_spi_partner.sv
/*
  Behavioural master and slave pair driving an observed serial bus.
  Assumes the monitor samples these lines on its own clock.
*/
`timescale 1ns/1ps
module smd_spi_partner (
  // Observed bus lines
  output logic sclk_out,
  output logic cs_out,
  output logic mosi_out,
  output logic miso_out
);
  // Quiet bus at time zero
  initial begin
    sclk_out = 1'b0;
    cs_out = 1'b1;
    mosi_out = 1'b0;
    miso_out = 1'b0;
  end

  // Park clock at its idle level and select at a chosen level
  task automatic park(input logic idle, input logic cs_lvl);
    sclk_out = idle;
    cs_out = cs_lvl;
  endtask

  // One frame, first bit from the top of n bits, 160 ns per bit
  task automatic xfer(input logic [31:0] mo, input logic [31:0] mi,
                      input int n, input logic idle, input logic cs_act,
                      input logic use_cs);
    if (use_cs) cs_out = cs_act;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = mo[i];
      miso_out = mi[i];
      #80 sclk_out = ~idle;
      #80 sclk_out = idle;
    end
    #80;
    // Released data shows no held value, so stale bits cannot pass
    mosi_out = ~mosi_out;
    miso_out = ~miso_out;
    if (use_cs) cs_out = ~cs_act;
    #200;
  endtask
endmodule

//--- tb/smd_monitor_bench.sv
/*
  Self-checking bench for the serial bus monitor.
  Assumes the partner model drives the observed lines.
*/
`timescale 1ns/1ps
module smd_monitor_bench
  import smd_pkg::*;
();
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic word_ready = 1'b1;
  smd_cfg_t cfg = '0;
  smd_word_t word;
  logic word_valid, trig, fs, fe, in_frame, claimed, ovf;
  logic sclk, cs, mosi, miso;
  int err_count = 0;
  int check_count = 0;
  int n_fs, n_fe, n_trig;
  smd_word_t got[$];

  // 100 MHz sampling clock
  always #5 clk_in = ~clk_in;

  smd_spi_partner smd_spi_partner_i (
    .sclk_out(sclk),
    .cs_out(cs),
    .mosi_out(mosi),
    .miso_out(miso)
  );

  smd_monitor #(.INSTANCE(1), .DEPTH(FIFO_DEPTH)) smd_monitor_i (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sclk_in(sclk),
    .cs_in(cs),
    .mosi_in(mosi),
    .miso_in(miso),
    .cfg_in(cfg),
    .word_out(word),
    .word_valid_out(word_valid),
    .word_ready_in(word_ready),
    .trig_out(trig),
    .frame_start_out(fs),
    .frame_end_out(fe),
    .in_frame_out(in_frame),
    .partner_claimed_out(claimed),
    .overflow_out(ovf)
  );

  // Collect accepted words and count event pulses
  always @(posedge clk_in) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) got.push_back(word);
    if (fs === 1'b1) n_fs++;
    if (fe === 1'b1) n_fe++;
    if (trig === 1'b1) n_trig++;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic smd_cfg_t base();
    smd_cfg_t c;
    c = '0;
    c.cs_mode = 1'b1;
    c.cs_act_high = POL_CS_RST;
    c.mosi_act_high = POL_DATA_RST;
    c.miso_act_high = POL_DATA_RST;
    c.miso_en = 1'b1;
    c.word_size = WSIZE_RST;
    c.idle_cyc = 16'h00C8;
    c.trig_mode = SMD_TRIG_START;
    return c;
  endfunction

  // Reconfigure under reset so a polarity change cannot fake a frame
  task automatic restart(input smd_cfg_t c);
    @(posedge clk_in) #1;
    rst_in = 1'b1;
    cfg = c;
    word_ready = 1'b1;
    smd_spi_partner_i.park(c.slope_fall, ~c.cs_act_high);
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    // Counting from release makes a false frame after reset visible
    got.delete();
    n_fs = 0;
    n_fe = 0;
    n_trig = 0;
    repeat (5) @(posedge clk_in);
  endtask

  task automatic frame(input logic [31:0] mo, input logic [31:0] mi,
                       input int n);
    @(posedge clk_in) #1;
    smd_spi_partner_i.xfer(mo, mi, n, cfg.slope_fall, cfg.cs_act_high,
                           cfg.cs_mode);
    repeat (30) @(posedge clk_in);
  endtask

  task automatic t_basic();
    restart(base());
    chk("idle frame", in_frame, 32'h0);
    frame(32'h000000A5, 32'h0000003C, 8);
    chk("starts", n_fs, 32'h1);
    chk("ends", n_fe, 32'h1);
    chk("start trig", n_trig, 32'h1);
    chk("words", got.size(), 32'h1);
    chk("mosi", got[0].mosi, 32'h000000A5);
    chk("miso", got[0].miso, 32'h0000003C);
    chk("nbits", 32'(got[0].nbits), 32'h8);
    chk("first", 32'(got[0].first), 32'h1);
    chk("claimed", claimed, 32'h1);
    $display("basic test finished");
  endtask

  task automatic t_lsb();
    smd_cfg_t c;
    c = base();
    c.slope_fall = 1'b1;
    c.lsb_first = 1'b1;
    c.cs_act_high = 1'b1;
    c.mosi_act_high = 1'b0;
    c.miso_act_high = 1'b0;
    c.trig_mode = SMD_TRIG_END;
    restart(c);
    frame(32'h000000C1, 32'h0000000F, 8);
    chk("lsb mosi", got[0].mosi, 32'h0000007C);
    chk("lsb miso", got[0].miso, 32'h0000000F);
    chk("end trig", n_trig, 32'h1);
    chk("fall starts", n_fs, 32'h1);
    $display("order test finished");
  endtask

  task automatic t_partial();
    smd_cfg_t c;
    c = base();
    restart(c);
    frame(32'h00000ABC, 32'h00000123, 12);
    chk("w0 mosi", got[0].mosi, 32'h000000AB);
    chk("w0 last", 32'(got[0].last), 32'h0);
    chk("w1 mosi", got[1].mosi, 32'h0000000C);
    chk("w1 miso", got[1].miso, 32'h00000003);
    chk("w1 nbits", 32'(got[1].nbits), 32'h4);
    chk("w1 last", 32'(got[1].last), 32'h1);
    chk("w1 idx", 32'(got[1].word_idx), 32'h1);
    got.delete();
    frame(32'h00000005, 32'h00000002, 3);
    chk("new idx", 32'(got[0].word_idx), 32'h0);
    chk("new first", 32'(got[0].first), 32'h1);
    chk("new mosi", got[0].mosi, 32'h00000005);
    c.word_size = 6'h20;
    restart(c);
    frame(32'h8421C3A5, 32'h00000000, 32);
    chk("wide mosi", got[0].mosi, 32'h8421C3A5);
    chk("wide nbits", 32'(got[0].nbits), 32'h20);
    $display("partial test finished");
  endtask

  task automatic t_nocs();
    smd_cfg_t c;
    c = base();
    c.cs_mode = 1'b0;
    c.miso_en = 1'b0;
    restart(c);
    smd_spi_partner_i.park(1'b0, 1'b0);
    frame(32'h00000012, 32'h000000FF, 8);
    frame(32'h00000034, 32'h00000000, 8);
    repeat (300) @(posedge clk_in);
    frame(32'h00000056, 32'h00000000, 8);
    repeat (300) @(posedge clk_in);
    chk("idle starts", n_fs, 32'h2);
    chk("idle ends", n_fe, 32'h2);
    chk("idle words", got.size(), 32'h3);
    chk("gap idx", 32'(got[1].word_idx), 32'h1);
    chk("gap mosi", got[1].mosi, 32'h00000034);
    chk("after idx", 32'(got[2].word_idx), 32'h0);
    chk("unused line", got[0].miso, 32'h00000000);
    chk("no claim", claimed, 32'h0);
    $display("idle test finished");
  endtask

  task automatic trig_case(input smd_trig_t m, input logic tm,
                           input logic [15:0] off, input logic [31:0] mo,
                           input logic [31:0] mi, input logic [31:0] exp);
    smd_cfg_t c;
    c = base();
    c.trig_mode = m;
    c.trig_miso = tm;
    c.bit_offset = off;
    c.pat_len = 6'h04;
    c.pat_val = 32'h0000000B;
    c.pat_care = 32'h0000000F;
    restart(c);
    frame(mo, mi, 8);
    chk("trigger", n_trig, exp);
  endtask

  task automatic t_fifo();
    logic [31:0] mo;
    mo = 32'h005AC396;
    restart(base());
    cfg.word_size = 6'h01;
    @(posedge clk_in) #1 word_ready = 1'b0;
    frame(mo, 32'h00000000, 24);
    chk("overflow", ovf, 32'h1);
    @(posedge clk_in) #1 word_ready = 1'b1;
    repeat (60) @(posedge clk_in);
    chk("drained", got.size(), 32'h10);
    for (int i = 0; i < 16; i++) begin
      chk("drain bit", 32'(got[i].mosi[0]), 32'(mo[23 - i]));
    end
    restart(base());
    chk("overflow cleared", ovf, 32'h0);
    $display("buffer test finished");
  endtask

  // Watchdog sized well above the whole test sequence
  initial begin
    #500000;
    err_count++;
    $display("watchdog expired");
    complete_run();
  end

  // Main sequence
  initial begin
    t_basic();
    t_lsb();
    t_partial();
    t_nocs();
    trig_case(SMD_TRIG_BIT, 1'b0, 16'h0004, 32'hFF, 32'h0, 32'h1);
    trig_case(SMD_TRIG_BIT, 1'b0, 16'h0008, 32'hFF, 32'h0, 32'h0);
    trig_case(SMD_TRIG_PATTERN, 1'b0, 16'h0002, 32'h2C, 32'h0, 32'h1);
    trig_case(SMD_TRIG_PATTERN, 1'b0, 16'h0002, 32'hB0, 32'h0, 32'h0);
    trig_case(SMD_TRIG_PATTERN, 1'b1, 16'h0002, 32'h2C, 32'h0, 32'h0);
    trig_case(SMD_TRIG_PATTERN, 1'b1, 16'h0002, 32'h0, 32'h2C, 32'h1);
    $display("trigger test finished");
    t_fifo();
    complete_run();
  end
endmodule
